// ### csw_ctrl.sv
`timescale 1ns/10ps
`include "csw_cfg.svh"
module csw_ctrl #(
	parameter logic [6:0]  SLAVE_ADDR   = `CSW_SMB_ADDR,
	parameter logic [3:0]  VENDOR_ID    = `CSW_VENDOR_ID,
	parameter logic [3:0]  REVISION     = `CSW_REVISION,
	parameter int unsigned WD_SHORT_CYC = `CSW_WD_SHORT_CYC,
	parameter int unsigned WD_LONG_CYC  = `CSW_WD_LONG_CYC,
	parameter int unsigned SRST_CYC     = `CSW_SRST_PULSE_CYC
) (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       smb_clk_i,
	input  wire logic       smb_data_i,
	output logic            smb_data_o,
	output logic            smb_data_oe_o,
	input  wire logic       link_clock_request_a_n_i,
	input  wire logic       link_clock_request_b_n_i,
	output logic [2:0]      link_out_run_o,
	input  wire logic [1:0] freq_control_pins_i,
	input  wire logic       dynfreq_enable_i,
	input  wire logic       watchdog_autorecover_i,
	output logic            cpu_dynfreq_active_o,
	output logic [8:0]      cpu_dynfreq_divider_o,
	output logic            smooth_transition_active_o,
	output logic            smooth_switch_target_o,
	output logic            recovery_src_prog_o,
	output logic            recovery_reload_o,
	output logic            system_reset_out_n_o,
	output logic            watchdog_alarm_flag_o
);

	// Reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// Register storage
	logic [2:0] link_gate_q;
	logic [8:0] df_one_q;
	logic [8:0] df_two_q;
	logic [8:0] df_three_q;
	logic       bypass_q;
	logic       target_q;
	logic       rec_src_q;
	logic       action_q;
	logic       scale_q;
	logic [2:0] mult_q;
	logic       watchdog_enable_q;
	logic       alarm_q;
	logic       wd_start_q;

	// Bus engine state
	csw_pkg::csw_smb_state_t state_q;
	csw_pkg::csw_smb_state_t state_d;
	csw_pkg::csw_wr_t        wr_q;
	csw_pkg::csw_wr_t        wr_d;
	logic                    scl_q;
	logic                    sda_q;
	logic [2:0]              cnt_q;
	logic [2:0]              cnt_d;
	logic [7:0]              shift_q;
	logic [7:0]              shift_d;
	logic [7:0]              tx_q;
	logic [7:0]              tx_d;
	logic [7:0]              ptr_q;
	logic [7:0]              ptr_d;
	logic                    oe_q;
	logic                    oe_d;
	logic                    rw_q;
	logic                    rw_d;
	logic                    done_q;
	logic                    done_d;
	logic                    nack_q;
	logic                    nack_d;

	function automatic logic [7:0] reg_image(input logic [7:0] a);
		case (a)
			`CSW_OFS_ID:   reg_image = {REVISION, VENDOR_ID};
			`CSW_OFS_LINK: reg_image = {1'b0, link_gate_q, 4'h0};
			`CSW_OFS_DFHI: reg_image = {df_three_q[8], df_two_q[8], df_one_q[8], 2'b00, bypass_q, target_q, 1'b0};
			`CSW_OFS_DF1:  reg_image = df_one_q[7:0];
			`CSW_OFS_DF2:  reg_image = df_two_q[7:0];
			`CSW_OFS_DF3:  reg_image = df_three_q[7:0];
			`CSW_OFS_WDT:  reg_image = {rec_src_q, action_q, scale_q, alarm_q, mult_q, watchdog_enable_q};
			default:       reg_image = 8'h00;
		endcase
	endfunction

	function automatic logic wr_hit(input csw_pkg::csw_wr_t w, input logic [7:0] ofs);
		wr_hit = w.en && (w.addr == ofs);
	endfunction

	// Bus line events
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [7:0] rd_byte;

	assign scl_rise   = ~scl_q & smb_clk_i;
	assign scl_fall   = scl_q & ~smb_clk_i;
	assign start_cond = scl_q & smb_clk_i & sda_q & ~smb_data_i;
	assign stop_cond  = scl_q & smb_clk_i & ~sda_q & smb_data_i;

	always_comb begin
		rd_byte = reg_image(ptr_q);
	end

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		tx_d    = tx_q;
		oe_d    = oe_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		done_d  = done_q;
		nack_d  = nack_q;
		wr_d    = '0;
		if (stop_cond) begin
			state_d = csw_pkg::CSW_IDLE;
			oe_d    = 1'b0;
		end else if (start_cond) begin
			state_d = csw_pkg::CSW_ADDR;
			cnt_d   = 3'h0;
			done_d  = 1'b0;
			oe_d    = 1'b0;
		end else if (scl_rise) begin
			if (state_q == csw_pkg::CSW_ADDR || state_q == csw_pkg::CSW_CMD || state_q == csw_pkg::CSW_WDATA) begin
				shift_d = {shift_q[6:0], smb_data_i};
				cnt_d   = cnt_q + 3'h1;
				done_d  = (cnt_q == 3'h7);
			end else if (state_q == csw_pkg::CSW_RDATA) begin
				cnt_d  = cnt_q + 3'h1;
				done_d = (cnt_q == 3'h7);
			end else if (state_q == csw_pkg::CSW_RACK) begin
				nack_d = smb_data_i;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				csw_pkg::CSW_IDLE: begin
				end
				csw_pkg::CSW_ADDR: begin
					if (done_q) begin
						done_d = 1'b0;
						if (shift_q[7:1] == SLAVE_ADDR) begin
							oe_d    = 1'b1;
							rw_d    = shift_q[0];
							state_d = csw_pkg::CSW_ADDR_ACK;
						end else begin
							state_d = csw_pkg::CSW_IDLE;
						end
					end
				end
				csw_pkg::CSW_ADDR_ACK: begin
					cnt_d = 3'h0;
					if (rw_q) begin
						tx_d    = rd_byte;
						oe_d    = ~rd_byte[7];
						state_d = csw_pkg::CSW_RDATA;
					end else begin
						oe_d    = 1'b0;
						state_d = csw_pkg::CSW_CMD;
					end
				end
				csw_pkg::CSW_CMD: begin
					if (done_q) begin
						done_d  = 1'b0;
						ptr_d   = shift_q;
						oe_d    = 1'b1;
						state_d = csw_pkg::CSW_CMD_ACK;
					end
				end
				csw_pkg::CSW_CMD_ACK, csw_pkg::CSW_WR_ACK: begin
					oe_d    = 1'b0;
					cnt_d   = 3'h0;
					state_d = csw_pkg::CSW_WDATA;
				end
				csw_pkg::CSW_WDATA: begin
					if (done_q) begin
						done_d  = 1'b0;
						wr_d    = '{en: 1'b1, addr: ptr_q, data: shift_q};
						ptr_d   = ptr_q + 8'h01;
						oe_d    = 1'b1;
						state_d = csw_pkg::CSW_WR_ACK;
					end
				end
				csw_pkg::CSW_RDATA: begin
					if (done_q) begin
						done_d  = 1'b0;
						oe_d    = 1'b0;
						ptr_d   = ptr_q + 8'h01;
						state_d = csw_pkg::CSW_RACK;
					end else begin
						tx_d = {tx_q[6:0], 1'b0};
						oe_d = ~tx_q[6];
					end
				end
				csw_pkg::CSW_RACK: begin
					if (nack_q) begin
						state_d = csw_pkg::CSW_IDLE;
					end else begin
						tx_d    = rd_byte;
						oe_d    = ~rd_byte[7];
						cnt_d   = 3'h0;
						state_d = csw_pkg::CSW_RDATA;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= csw_pkg::CSW_IDLE;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			{cnt_q, shift_q, tx_q, ptr_q} <= '0;
			{oe_q, rw_q, done_q, nack_q}  <= '0;
			wr_q    <= '0;
		end else begin
			state_q <= state_d;
			scl_q   <= smb_clk_i;
			sda_q   <= smb_data_i;
			{cnt_q, shift_q, tx_q, ptr_q} <= {cnt_d, shift_d, tx_d, ptr_d};
			{oe_q, rw_q, done_q, nack_q}  <= {oe_d, rw_d, done_d, nack_d};
			wr_q    <= wr_d;
		end
	end

	assign smb_data_o    = 1'b0;
	assign smb_data_oe_o = oe_q;

	// Register writes and watchdog flag
	logic wd_expire;
	logic alarm_clear;
	logic alarm_d;

	assign alarm_clear = wr_hit(wr_q, `CSW_OFS_WDT) && (wr_q.data[`CSW_WDT_MULT_HI:`CSW_WDT_MULT_LO] == 3'h0);
	assign alarm_d     = wd_expire | (alarm_q & ~alarm_clear);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_gate_q <= `CSW_LINK_RESET;
			{df_one_q, df_two_q, df_three_q} <= {3{`CSW_DF_RESET}};
			{bypass_q, target_q, rec_src_q, action_q} <= 4'h0;
			scale_q    <= `CSW_SCALE_RESET;
			mult_q     <= `CSW_MULT_RESET;
			watchdog_enable_q    <= 1'b0;
			wd_start_q <= 1'b0;
			alarm_q    <= 1'b0;
		end else begin
			alarm_q    <= alarm_d;
			wd_start_q <= wr_hit(wr_q, `CSW_OFS_WDT) && wr_q.data[`CSW_WDT_EN];
			if (wr_hit(wr_q, `CSW_OFS_LINK)) begin
				link_gate_q <= wr_q.data[`CSW_LINK_GATE_HI:`CSW_LINK_GATE_LO];
			end
			if (wr_hit(wr_q, `CSW_OFS_DFHI)) begin
				df_three_q[8] <= wr_q.data[`CSW_DFHI_THREE];
				df_two_q[8]   <= wr_q.data[`CSW_DFHI_TWO];
				df_one_q[8]   <= wr_q.data[`CSW_DFHI_ONE];
				bypass_q      <= wr_q.data[`CSW_DFHI_BYPASS];
				target_q      <= wr_q.data[`CSW_DFHI_TARGET];
			end
			if (wr_hit(wr_q, `CSW_OFS_DF1)) begin
				df_one_q[7:0] <= wr_q.data;
			end
			if (wr_hit(wr_q, `CSW_OFS_DF2)) begin
				df_two_q[7:0] <= wr_q.data;
			end
			if (wr_hit(wr_q, `CSW_OFS_DF3)) begin
				df_three_q[7:0] <= wr_q.data;
			end
			if (wr_hit(wr_q, `CSW_OFS_WDT)) begin
				rec_src_q <= wr_q.data[`CSW_WDT_REC_SRC];
				action_q  <= wr_q.data[`CSW_WDT_ACTION];
				scale_q   <= wr_q.data[`CSW_WDT_SCALE];
				mult_q    <= wr_q.data[`CSW_WDT_MULT_HI:`CSW_WDT_MULT_LO];
				watchdog_enable_q   <= wr_q.data[`CSW_WDT_EN];
			end
		end
	end

	// Link gating and frequency selection
	logic [2:0] link_run_d;
	logic [8:0] div_sel;
	logic       df_active;

	assign link_run_d[2] = ~link_gate_q[2] | ~link_clock_request_a_n_i;
	assign link_run_d[1] = ~link_gate_q[1] | ~link_clock_request_b_n_i;
	assign link_run_d[0] = ~link_gate_q[0] | ~link_clock_request_b_n_i;
	assign div_sel = (freq_control_pins_i == 2'b01) ? df_one_q :
	                 (freq_control_pins_i == 2'b10) ? df_two_q :
	                 (freq_control_pins_i == 2'b11) ? df_three_q : 9'h000;
	assign df_active = dynfreq_enable_i && (freq_control_pins_i != 2'b00);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_out_run_o        <= 3'h7;
			cpu_dynfreq_active_o  <= 1'b0;
			cpu_dynfreq_divider_o <= 9'h000;
			recovery_reload_o     <= 1'b0;
		end else begin
			link_out_run_o        <= link_run_d;
			cpu_dynfreq_active_o  <= df_active;
			cpu_dynfreq_divider_o <= df_active ? div_sel : cpu_dynfreq_divider_o;
			recovery_reload_o     <= wd_expire & ~action_q;
		end
	end

	assign smooth_transition_active_o = ~bypass_q;
	assign smooth_switch_target_o     = target_q;
	assign recovery_src_prog_o        = rec_src_q;
	assign watchdog_alarm_flag_o      = alarm_q;

	// Watchdog and system reset pulse
	csw_pkg::csw_wd_cfg_t wd_cfg;
	logic                 srst_pulse;

	assign wd_cfg = '{enable: watchdog_enable_q, start: wd_start_q, scale: scale_q, mult: mult_q};

	csw_watchdog #(
		.SHORT_CYC (WD_SHORT_CYC),
		.LONG_CYC  (WD_LONG_CYC)
	) u_watchdog (
		.clk_i         (sys_clk_i),
		.rst_n_i       (rst_n),
		.cfg_i         (wd_cfg),
		.autorecover_i (watchdog_autorecover_i),
		.expire_o      (wd_expire),
		.running_o     ()
	);

	csw_pulse_gen #(
		.WIDTH_CYC (SRST_CYC)
	) u_srst_pulse (
		.clk_i     (sys_clk_i),
		.rst_n_i   (rst_n),
		.trigger_i (wd_expire),
		.pulse_o   (srst_pulse)
	);

	assign system_reset_out_n_o = ~srst_pulse;

endmodule

// ### csw_cfg.svh
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH

// Register offsets
`define CSW_OFS_ID          8'h07
`define CSW_OFS_LINK        8'h08
`define CSW_OFS_DFHI        8'h09
`define CSW_OFS_DF1         8'h0a
`define CSW_OFS_DF2         8'h0b
`define CSW_OFS_DF3         8'h0c
`define CSW_OFS_WDT         8'h0d

// Byte 0x08 fields
`define CSW_LINK_GATE_HI    6
`define CSW_LINK_GATE_LO    4

// Byte 0x09 fields
`define CSW_DFHI_THREE      7
`define CSW_DFHI_TWO        6
`define CSW_DFHI_ONE        5
`define CSW_DFHI_BYPASS     2
`define CSW_DFHI_TARGET     1

// Byte 0x0d fields
`define CSW_WDT_REC_SRC     7
`define CSW_WDT_ACTION      6
`define CSW_WDT_SCALE       5
`define CSW_WDT_ALARM       4
`define CSW_WDT_MULT_HI     3
`define CSW_WDT_MULT_LO     1
`define CSW_WDT_EN          0

// Power-up values
`define CSW_LINK_RESET      3'h0
`define CSW_DF_RESET        9'h000
`define CSW_SCALE_RESET     1'b1
`define CSW_MULT_RESET      3'h0

// Identity codes, values are arbitrary
`define CSW_VENDOR_ID       4'h5
`define CSW_REVISION        4'h0
`define CSW_SMB_ADDR        7'h5a

// Timing
`define CSW_CLK_PERIOD_NS   64'd50
`define CSW_WD_SHORT_MS     64'd294
`define CSW_WD_LONG_MS      64'd2340
`define CSW_WD_SHORT_CYC    32'((`CSW_WD_SHORT_MS * 64'd1000000) / `CSW_CLK_PERIOD_NS)
`define CSW_WD_LONG_CYC     32'((`CSW_WD_LONG_MS * 64'd1000000) / `CSW_CLK_PERIOD_NS)
`define CSW_SRST_PULSE_NS   64'd1000
`define CSW_SRST_PULSE_CYC  32'((`CSW_SRST_PULSE_NS + `CSW_CLK_PERIOD_NS - 64'd1) / `CSW_CLK_PERIOD_NS)

`endif

// ### csw_pkg.sv
package csw_pkg;

	typedef enum logic [3:0] {
		CSW_IDLE,
		CSW_ADDR,
		CSW_ADDR_ACK,
		CSW_CMD,
		CSW_CMD_ACK,
		CSW_WDATA,
		CSW_WR_ACK,
		CSW_RDATA,
		CSW_RACK
	} csw_smb_state_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} csw_wr_t;

	typedef struct packed {
		logic       enable;
		logic       start;
		logic       scale;
		logic [2:0] mult;
	} csw_wd_cfg_t;

endpackage

// ### csw_pulse_gen.sv
`timescale 1ns/10ps
module csw_pulse_gen #(
	parameter int unsigned WIDTH_CYC = 20
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic trigger_i,
	output logic      pulse_o
);

	localparam int CW = $clog2(WIDTH_CYC + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	assign cnt_d = trigger_i ? CW'(WIDTH_CYC) : ((cnt_q != '0) ? cnt_q - CW'(1) : cnt_q);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q   <= '0;
			pulse_o <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			pulse_o <= (cnt_d != '0);
		end
	end

endmodule

// ### csw_watchdog.sv
`timescale 1ns/10ps
module csw_watchdog #(
	parameter int unsigned SHORT_CYC = 5880000,
	parameter int unsigned LONG_CYC  = 46800000
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire csw_pkg::csw_wd_cfg_t cfg_i,
	input  wire logic                 autorecover_i,
	output logic                      expire_o,
	output logic                      running_o
);

	logic [31:0] unit_q;
	logic [2:0]  left_q;
	logic [31:0] unit_len;
	logic        unit_end;
	logic        last_unit;

	assign unit_len  = cfg_i.scale ? LONG_CYC : SHORT_CYC;
	assign unit_end  = running_o && (unit_q >= unit_len - 32'd1);
	assign last_unit = (left_q <= 3'h1);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unit_q    <= '0;
			left_q    <= '0;
			running_o <= 1'b0;
			expire_o  <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (!cfg_i.enable) begin
				running_o <= 1'b0;
				unit_q    <= '0;
			end else if (cfg_i.start) begin
				running_o <= 1'b1;
				unit_q    <= '0;
				left_q    <= cfg_i.mult;
			end else if (unit_end) begin
				unit_q <= '0;
				if (last_unit) begin
					expire_o  <= 1'b1;
					running_o <= autorecover_i;
					left_q    <= cfg_i.mult;
				end else begin
					left_q <= left_q - 3'h1;
				end
			end else if (running_o) begin
				unit_q <= unit_q + 32'd1;
			end
		end
	end

endmodule

// ### csw_ctrl_chk.sv
`timescale 1ns/10ps
module csw_ctrl_chk #(
	parameter int unsigned SRST_CYC = 20
) (
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic       link_clock_request_a_n_i,
	input wire logic       link_clock_request_b_n_i,
	input wire logic [2:0] link_out_run_o,
	input wire logic [1:0] freq_control_pins_i,
	input wire logic       dynfreq_enable_i,
	input wire logic       cpu_dynfreq_active_o,
	input wire logic [8:0] cpu_dynfreq_divider_o,
	input wire logic       recovery_reload_o,
	input wire logic       system_reset_out_n_o,
	input wire logic       watchdog_alarm_flag_o
);
	logic [2:0]  up_q;
	logic [31:0] low_q;
	wire         live = up_q[2];
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			up_q  <= 3'h0;
			low_q <= 32'h0;
		end else begin
			up_q  <= {up_q[1:0], 1'b1};
			low_q <= system_reset_out_n_o ? 32'h0 : low_q + 32'h1;
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_expiry;
		$fell(system_reset_out_n_o) ##0 watchdog_alarm_flag_o;
	endsequence
	chk_out6_request_run:
		assert property (live && !link_clock_request_a_n_i |=> link_out_run_o[2]) else $error("out6 stopped");
	chk_out54_request_run:
		assert property (live && !link_clock_request_b_n_i |=> &link_out_run_o[1:0]) else $error("out5 or out4 stopped");
	chk_dyn_select_active:
		assert property (live && dynfreq_enable_i && freq_control_pins_i != 2'h0 |=> cpu_dynfreq_active_o)
		else $error("divider not selected");
	chk_dyn_disabled_idle:
		assert property (live && !dynfreq_enable_i |=> !cpu_dynfreq_active_o) else $error("selection while disabled");
	chk_dyn_divider_hold:
		assert property (live && !dynfreq_enable_i |=> $stable(cpu_dynfreq_divider_o)) else $error("divider moved");
	chk_reset_pulse_width:
		assert property (live && $rose(system_reset_out_n_o) |-> low_q == SRST_CYC) else $error("reset pulse width");
	chk_alarm_with_reset:
		assert property ($fell(system_reset_out_n_o) |-> s_expiry) else $error("reset without alarm");
	chk_alarm_rise_cause:
		assert property ($rose(watchdog_alarm_flag_o) |-> $fell(system_reset_out_n_o)) else $error("alarm without reset");
	chk_reload_one_pulse:
		assert property (recovery_reload_o |-> s_expiry ##1 !recovery_reload_o) else $error("reload pulse wrong");
endmodule
bind csw_ctrl csw_ctrl_chk #(.SRST_CYC(SRST_CYC)) u_chk (
	.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i),
	.link_clock_request_a_n_i(link_clock_request_a_n_i),
	.link_clock_request_b_n_i(link_clock_request_b_n_i),
	.link_out_run_o(link_out_run_o),
	.freq_control_pins_i(freq_control_pins_i),
	.dynfreq_enable_i(dynfreq_enable_i),
	.cpu_dynfreq_active_o(cpu_dynfreq_active_o),
	.cpu_dynfreq_divider_o(cpu_dynfreq_divider_o),
	.recovery_reload_o(recovery_reload_o),
	.system_reset_out_n_o(system_reset_out_n_o),
	.watchdog_alarm_flag_o(watchdog_alarm_flag_o)
);

// ### csw_host_model.sv
`timescale 1ns/10ps
module csw_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h5a
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	localparam int HALF = 5;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hold();
		repeat (HALF) @(negedge clk_i);
	endtask
	task automatic start();
		sda_o = 1'b1;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_o = 1'b0;
		hold();
		scl_o = 1'b1;
		hold();
		sda_o = 1'b1;
		hold();
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic ka);
		for (int i = 7; i >= -1; i--) begin
			sda_o = (i < 0) ? ak : d[i];
			hold();
			scl_o = 1'b1;
			hold();
			if (i < 0) ka = sda_i;
			else r[i] = sda_i;
			scl_o = 1'b0;
			hold();
		end
	endtask
	function automatic logic [7:0] keep(input logic [7:0] a);
		case (a)
			8'h08: return 8'h70;
			8'h09: return 8'he6;
			default: return 8'hff;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic ok);
		logic [7:0] r;
		logic [2:0] k;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r, k[0]);
		xfer(a, 1'b1, r, k[1]);
		xfer(v & keep(a), 1'b1, r, k[2]);
		stop();
		ok = (k == 3'h0);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
		logic [7:0] r;
		logic [3:0] k;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r, k[0]);
		xfer(a, 1'b1, r, k[1]);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, r, k[2]);
		xfer(8'hff, 1'b1, v, k[3]);
		stop();
		ok = (k[2:0] == 3'h0) && k[3];
	endtask
endmodule

// ### testbench.sv
`timescale 1ns/10ps
`include "csw_cfg.svh"
module testbench;
	localparam int SHORT = 20;
	localparam int LONG  = 50;
	localparam int SRST  = 3;
	logic       sys_clk, nrst, scl, host_sda, sda_o, sda_oe;
	logic       req_a_n, req_b_n, dyn_en, auto_rec, dyn_act;
	logic       smooth_act, smooth_tgt, rec_src, reload, srst_n, alarm, ok, prev;
	logic [2:0] run;
	logic [1:0] pins;
	logic [8:0] dyn_div;
	logic [7:0] rv, v;
	logic [8:0] dv [3];
	int         err_total, samples_checked, cycles, n_rst, n_rel, r0;
	wire        sda_line = host_sda & ~(sda_oe & ~sda_o);
	csw_host_model host (.clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
	csw_ctrl #(.WD_SHORT_CYC(SHORT), .WD_LONG_CYC(LONG), .SRST_CYC(SRST)) DUT (
		.sys_clk_i(sys_clk), .nrst_i(nrst), .smb_clk_i(scl), .smb_data_i(sda_line),
		.smb_data_o(sda_o), .smb_data_oe_o(sda_oe),
		.link_clock_request_a_n_i(req_a_n), .link_clock_request_b_n_i(req_b_n),
		.link_out_run_o(run), .freq_control_pins_i(pins), .dynfreq_enable_i(dyn_en),
		.watchdog_autorecover_i(auto_rec), .cpu_dynfreq_active_o(dyn_act),
		.cpu_dynfreq_divider_o(dyn_div), .smooth_transition_active_o(smooth_act),
		.smooth_switch_target_o(smooth_tgt), .recovery_src_prog_o(rec_src),
		.recovery_reload_o(reload), .system_reset_out_n_o(srst_n), .watchdog_alarm_flag_o(alarm));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(negedge sys_clk) begin
		cycles++;
		if (prev === 1'b1 && srst_n === 1'b0) n_rst++;
		if (reload === 1'b1) n_rel++;
		prev = srst_n;
		if (cycles == 60000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic compare(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d, ok);
		compare(ok, 1'b1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		host.rd(a, rv, ok);
		compare({ok, rv & m}, {1'b1, e & m});
	endtask
	function automatic logic [2:0] exp_run(input logic [2:0] g, input logic a_n, input logic b_n);
		return ~g | {~a_n, ~b_n, ~b_n};
	endfunction
	task automatic wd(input logic [7:0] c, input int t, input int rel);
		int n;
		r0 = n_rel;
		n = 0;
		wr(`CSW_OFS_WDT, c);
		while (srst_n === 1'b1 && n < t + 10) begin
			n++;
			@(negedge sys_clk);
		end
		compare(n > t - 40 && n <= t, 1'b1);
		repeat (SRST + 2) @(negedge sys_clk);
		compare(alarm, 1'b1);
		compare(9'(n_rel - r0), 9'(rel));
	endtask
	initial begin
		{nrst, req_a_n, req_b_n, pins, dyn_en, auto_rec, prev} = 8'h31;
		{err_total, samples_checked, cycles, n_rst, n_rel} = '0;
		void'($urandom(32'ha9b7));
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (5) @(negedge sys_clk);
		rdc(`CSW_OFS_WDT, 8'h20);
		rdc(`CSW_OFS_ID, {`CSW_REVISION, `CSW_VENDOR_ID});
		rdc(8'h20, 8'h00);
		$display("Test reset values done");
		for (int o = 7; o <= 12; o++) begin
			v = 8'($urandom);
			wr(o[7:0], v);
			rdc(o[7:0], (o == 7) ? {`CSW_REVISION, `CSW_VENDOR_ID} : v & host.keep(o[7:0]));
		end
		$display("Test register access done");
		for (int g = 0; g < 8; g++) begin
			wr(`CSW_OFS_LINK, {1'b0, g[2:0], 4'h0});
			for (int p = 0; p < 4; p++) begin
				{req_a_n, req_b_n} = p[1:0];
				repeat (2) @(negedge sys_clk);
				compare(run, exp_run(g[2:0], p[1], p[0]));
			end
		end
		$display("Test link gating done");
		for (int i = 0; i < 3; i++) begin
			dv[i] = 9'($urandom);
			wr(`CSW_OFS_DF1 + i[7:0], dv[i][7:0]);
		end
		wr(`CSW_OFS_DFHI, {dv[2][8], dv[1][8], dv[0][8], 5'h0});
		for (int e = 1; e >= 0; e--) begin
			for (int p = 0; p < 4; p++) begin
				dyn_en = e[0];
				pins = p[1:0];
				repeat (2) @(negedge sys_clk);
				compare(dyn_act, e != 0 && p != 0);
				if (e != 0 && p != 0) compare(dyn_div, dv[p - 1]);
				if (e == 0) compare(dyn_div, dv[2]);
			end
		end
		$display("Test dynamic dividers done");
		for (int s = 0; s < 4; s++) begin
			wr(`CSW_OFS_DFHI, {5'h0, s[1:0], 1'b0});
			compare({smooth_act, smooth_tgt}, {~s[1], s[0]});
		end
		$display("Test smooth switch done");
		wd(8'h8f, 7 * SHORT, 1);
		compare(rec_src, 1'b1);
		rdc(`CSW_OFS_WDT, 8'h10, 8'h10);
		wr(`CSW_OFS_WDT, 8'h20);
		compare(alarm, 1'b0);
		wd(8'h63, LONG, 0);
		compare(rec_src, 1'b0);
		wr(`CSW_OFS_WDT, 8'h00);
		auto_rec = 1'b1;
		wd(8'h43, SHORT, 0);
		r0 = n_rst;
		repeat (SHORT + 10) @(negedge sys_clk);
		compare(n_rst > r0, 1'b1);
		wr(`CSW_OFS_WDT, 8'h02);
		r0 = n_rst;
		repeat (3 * SHORT) @(negedge sys_clk);
		compare(n_rst == r0, 1'b1);
		auto_rec = 1'b0;
		$display("Test watchdog done");
		print_verdict();
	end
endmodule
